// ### pkg/asr_if.sv
// link wires between host and converter end
`timescale 1ns/10ps
interface asr_if;
  logic convert_start;
  logic sck;
  logic serial_in_select;
  logic serial_out;
  logic serial_out_oe;
  modport device (
    input  convert_start,
    input  sck,
    input  serial_in_select,
    output serial_out,
    output serial_out_oe
  );
  modport host (
    output convert_start,
    output sck,
    output serial_in_select,
    input  serial_out,
    input  serial_out_oe
  );
endinterface : asr_if

// ### pkg/asr_pkg.sv
// shared constants for the serial converter readout link
package asr_pkg;
  localparam int RESULT_BITS      = 16;
  localparam int MCLK_PERIOD_NS   = 50;
  localparam int CONV_TIME_NS     = 1600;
  localparam int CONV_CYCLES_LINK = 267;
  localparam int CONV_CYCLES_MCLK = (CONV_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int QUIET_PRE_NS     = 30;
  localparam int QUIET_POST_NS    = 10;
  localparam int QUIET_PRE_CYC    = (QUIET_PRE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int QUIET_POST_CYC   = (QUIET_POST_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int SCK_DIV          = 2;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  typedef enum logic [1:0] {
    ASR_MODE_CS4,
    ASR_MODE_CS3,
    ASR_MODE_CHAIN
  } asr_mode_e;
endpackage : asr_pkg

// ### rtl/asr_device.sv
// converter end: mode capture, internal conversion timer, serial shifter
// Function
// [RL1] four wires carry all six modes
// [RL2] mode set by pin levels only
// [RL3] select high at start picks chip-select
// [RL4] chain: sck level enables busy
// [RL5] chain: stage shifts select input through
// [RL6] host clocks M times N edges
// [RL7] chain stages all sample together
// [RL8] no busy: host waits max conversion
// [RL9] chain busy: output rises when done
// [RL10] chain busy: host adds flush clock
// [RL11] four-wire: select input picks device
// [RL12] three-wire: start pin also selects
// [RL13] chip-select busy: host adds clock
// [RL14] early select gives busy drive-on
// [RL15] late select drives msb at once
// [RL16] host quiet after first quarter
// [RL17] host requests busy early
// [RL18] host keeps pins static near start
// [RL19] host runs sck in bursts
// [RL20] low power after each conversion
// [RL21] start rising begins conversion
// [RL22] internal clock times conversion
// [RL23] bits on sck falls, released after; in chain mode serial_out_oe stays high until reset or the next chip-select start releases it
// [RL24] conversion flag drives busy decision
`timescale 1ns/10ps
module asr_device
  import asr_pkg::*;
#(
  parameter int          CONV_CYCLES = CONV_CYCLES_LINK,
  parameter int          BITS        = RESULT_BITS
) (
  asr_if.device          link,
  input  wire logic      CONV_CLK,
  input  wire logic      RST_N,
  input  wire logic [BITS-1:0] SAMPLE,
  output logic           LOW_POWER,
  output logic           CONVERTING
);
  initial begin
    // timer counter is 16 bits wide, fall counter 6 bits
    if (CONV_CYCLES < 1 || CONV_CYCLES > 65536) $error("asr_device: bad conversion length");
    if (BITS < 2 || BITS > 32) $error("asr_device: bad result width");
  end

  logic [2:0]          pins_s;
  logic                start_s, sck_s, sel_s;
  logic                start_p_q, sck_p_q;
  logic                chain_q, busy_en_q;
  logic                conv_q;
  logic [15:0]         cnt_q;
  logic [BITS-1:0]     shift_q;
  logic [5:0]          fall_cnt_q;
  logic                done_q, drive_q, out_q, busy_armed_q;
  logic                chain_flush_q;
  logic                low_power_q;
  logic                start_rise, sck_fall, selected;

  // link pins are asynchronous to the conversion clock
  asr_sync #(.WIDTH(3)) u_sync (
    .clk   (CONV_CLK),
    .rst_n (RST_N),
    .d     ({link.convert_start, link.sck, link.serial_in_select}),
    .q     (pins_s)
  );
  assign start_s    = pins_s[2];
  assign sck_s      = pins_s[1];
  assign sel_s      = pins_s[0];
  assign start_rise = start_s & ~start_p_q; // RL21 RL7
  assign sck_fall   = sck_p_q & ~sck_s;
  // four-wire: select low; three-wire: start low too (select tied high)
  assign selected   = ~sel_s | ~start_s; // RL11 RL12

  always_ff @(posedge CONV_CLK or negedge RST_N) begin
    if (!RST_N) begin
      start_p_q <= 1'b0;
      sck_p_q   <= 1'b0;
    end else begin
      start_p_q <= start_s;
      sck_p_q   <= sck_s;
    end
  end

  // mode capture at the start edge
  always_ff @(posedge CONV_CLK or negedge RST_N) begin
    if (!RST_N) begin
      chain_q   <= 1'b0;
      busy_en_q <= 1'b0;
    end else if (start_rise) begin
      chain_q   <= ~sel_s; // RL2 RL3 RL1
      busy_en_q <= ~sel_s & sck_s; // RL4
    end
  end

  // conversion flag and internal timer
  always_ff @(posedge CONV_CLK or negedge RST_N) begin
    if (!RST_N) begin
      conv_q <= 1'b0;
      cnt_q  <= 16'h0000;
    end else if (start_rise) begin
      conv_q <= 1'b1; // RL24
      cnt_q  <= 16'(CONV_CYCLES - 1);
    end else if (conv_q) begin
      if (cnt_q == 16'h0000) conv_q <= 1'b0; // RL22 RL24
      else cnt_q <= cnt_q - 16'h0001;
    end
  end

  // low power as each conversion ends, no host command needed
  always_ff @(posedge CONV_CLK or negedge RST_N) begin
    if (!RST_N) begin
      low_power_q <= 1'b1;
    end else if (start_rise) begin
      low_power_q <= 1'b0;
    end else if (conv_q && cnt_q == 16'h0000) begin
      low_power_q <= 1'b1; // RL20
    end
  end

  assign LOW_POWER  = low_power_q; // RL20
  assign CONVERTING = conv_q;

  // chip-select busy request latched while converting
  always_ff @(posedge CONV_CLK or negedge RST_N) begin
    if (!RST_N) begin
      busy_armed_q <= 1'b0;
    end else if (start_rise) begin
      busy_armed_q <= 1'b0;
    end else if (conv_q && !chain_q && selected) begin
      busy_armed_q <= 1'b1; // RL14 RL17
    end
  end

  // result shifter and output drive
  always_ff @(posedge CONV_CLK or negedge RST_N) begin
    if (!RST_N) begin
      shift_q    <= '0;
      fall_cnt_q <= 6'h00;
      done_q     <= 1'b0;
      drive_q    <= 1'b0;
      out_q      <= 1'b0;
      chain_flush_q <= 1'b0;
    end else if (start_rise) begin
      fall_cnt_q <= 6'h00;
      done_q     <= 1'b0;
      chain_flush_q <= 1'b0;
      drive_q    <= ~sel_s; // chain drives low from the start
      out_q      <= 1'b0;
    end else if (conv_q && cnt_q == 16'h0000) begin
      shift_q <= SAMPLE;
      done_q  <= 1'b1;
      chain_flush_q <= chain_q & busy_en_q;
      if (chain_q) begin
        drive_q <= 1'b1;
        out_q   <= busy_en_q ? 1'b1 : SAMPLE[BITS-1]; // RL9
      end else if (busy_armed_q || selected) begin
        drive_q <= 1'b1; // RL14
        out_q   <= busy_armed_q ? 1'b0 : SAMPLE[BITS-1];
      end
    end else if (!conv_q && chain_q && done_q) begin
      if (sck_fall) begin
        if (chain_flush_q) begin
          // first fall only clears the start bit, msb follows
          chain_flush_q <= 1'b0; // RL9
          out_q         <= shift_q[BITS-1];
        end else begin
          // stage of a shift register: pull in upstream bit
          shift_q <= {shift_q[BITS-2:0], sel_s}; // RL5
          out_q   <= shift_q[BITS-2];
        end
      end
    end else if (!conv_q && !chain_q && done_q) begin
      if (!selected) begin
        drive_q    <= 1'b0; // RL23
        fall_cnt_q <= 6'h00;
      end else if (!drive_q && fall_cnt_q == 6'h00) begin
        drive_q <= 1'b1; // RL15
        out_q   <= shift_q[BITS-1];
      end else if (sck_fall && drive_q) begin
        fall_cnt_q <= fall_cnt_q + 6'h01;
        if (busy_armed_q && fall_cnt_q == 6'h00) begin
          out_q <= shift_q[BITS-1]; // RL14
        end else begin
          out_q   <= shift_q[BITS-2];
          shift_q <= {shift_q[BITS-2:0], 1'b0};
        end
        if (fall_cnt_q == 6'(BITS - 1 + (busy_armed_q ? 1 : 0))) begin
          drive_q <= 1'b0; // RL23
        end
      end
    end
  end

  assign link.serial_out    = out_q;
  assign link.serial_out_oe = drive_q;
endmodule : asr_device

// ### rtl/asr_host.sv
// host end: starts conversions, waits, clocks the result in
`timescale 1ns/10ps
module asr_host
  import asr_pkg::*;
#(
  parameter int BITS   = RESULT_BITS,
  parameter int STAGES = 1
) (
  asr_if.host                       link,
  input  wire logic                 MCLK,
  input  wire logic                 RST_N,
  input  wire logic                 START,
  input  wire asr_mode_e            MODE,
  input  wire logic                 BUSY_EN,
  output logic                      DONE,
  output logic [BITS*STAGES-1:0]    DATA
);
  initial begin
    if (BITS < 2 || STAGES < 1 || STAGES > 8) $error("asr_host: bad parameters");
  end
  typedef enum logic [2:0] {IDLE, SETUP, CONV, WAITB, SHIFT, FIN} asr_st_e;
  localparam int TOTAL = BITS * STAGES;
  asr_st_e      st_q;
  logic [15:0]  cnt_q;
  logic [7:0]   bit_q;
  logic         cs_q, sel_q, sck_q, flush_q, done_q;
  logic [TOTAL-1:0] data_q;
  logic [1:0]   sdo_s;
  logic [1:0]   ph_q;

  asr_sync #(.WIDTH(2)) u_sync (
    .clk   (MCLK),
    .rst_n (RST_N),
    .d     ({link.serial_out, link.serial_out_oe}),
    .q     (sdo_s)
  );

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= IDLE; cnt_q <= 16'h0000; bit_q <= 8'h00; cs_q <= 1'b0; sel_q <= 1'b1;
      sck_q <= 1'b0; flush_q <= 1'b0; done_q <= 1'b0; data_q <= '0; ph_q <= 2'b00;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        IDLE: if (START) begin
          sel_q <= (MODE != ASR_MODE_CHAIN);
          sck_q <= (MODE == ASR_MODE_CHAIN) && BUSY_EN;
          cnt_q <= 16'(QUIET_PRE_CYC);
          st_q  <= SETUP; // RL18
        end
        SETUP: if (cnt_q == 16'h0000) begin
          cs_q  <= 1'b1;
          cnt_q <= 16'(CONV_CYCLES_MCLK + QUIET_POST_CYC);
          st_q  <= CONV;
        end else cnt_q <= cnt_q - 16'h0001;
        CONV: begin
          sck_q <= 1'b0; // RL16
          if (BUSY_EN && MODE == ASR_MODE_CS4) sel_q <= 1'b0; // RL17
          if (BUSY_EN && MODE == ASR_MODE_CS3) cs_q <= 1'b0;
          if (BUSY_EN) begin
            st_q <= WAITB;
          end else if (cnt_q == 16'h0000) begin
            if (MODE == ASR_MODE_CS4) sel_q <= 1'b0;
            if (MODE == ASR_MODE_CS3) cs_q <= 1'b0;
            bit_q <= 8'h00; flush_q <= 1'b0; ph_q <= 2'b00;
            st_q  <= SHIFT; // RL8
          end else cnt_q <= cnt_q - 16'h0001;
        end
        WAITB: if (sdo_s[0] && (MODE != ASR_MODE_CHAIN || sdo_s[1])) begin // RL9 RL14
          bit_q <= 8'h00; flush_q <= 1'b1; ph_q <= 2'b00;
          st_q  <= SHIFT;
        end
        SHIFT: begin
          // four-cycle sck, bursts only; sample covers the 2-flop input delay
          ph_q <= ph_q + 2'b01;
          if (ph_q == 2'b00) sck_q <= 1'b1;
          else if (ph_q == 2'b10) sck_q <= 1'b0;
          else if (ph_q == 2'b11) begin
            if (flush_q) flush_q <= 1'b0; // RL10 RL13
            else begin
              data_q <= {data_q[TOTAL-2:0], sdo_s[1]};
              bit_q  <= bit_q + 8'h01;
              if (bit_q == 8'(TOTAL - 1)) st_q <= FIN; // RL6
            end
          end
        end
        FIN: begin
          sel_q <= 1'b1; cs_q <= 1'b0; done_q <= 1'b1; st_q <= IDLE; // RL19
        end
        default: st_q <= IDLE;
      endcase
    end
  end

  assign link.convert_start    = cs_q;
  assign link.sck              = sck_q;
  assign link.serial_in_select = sel_q;
  assign DONE = done_q;
  assign DATA = data_q;
endmodule : asr_host

// ### rtl/asr_sync.sv
// two-flop level synchroniser
`timescale 1ns/10ps
module asr_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : asr_sync

// ### verification/asr_link_props.sv
// concurrent checks on the converter link wires
`timescale 1ns/10ps
module asr_link_props
  import asr_pkg::*;
(
  input wire logic        CONV_CLK,
  input wire logic        RST_N,
  input wire logic        convert_start,
  input wire logic        sck,
  input wire logic        serial_in_select,
  input wire logic        serial_out,
  input wire logic        serial_out_oe,
  input wire logic        CONVERTING,
  input wire logic        LOW_POWER,
  input wire logic [15:0] SAMPLE
);
  logic       cnv_q, sck_q, cs_q, busy_q;
  logic [4:0] falls_q;

  default clocking @(posedge CONV_CLK); endclocking
  default disable iff (!RST_N);

  always_ff @(posedge CONV_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnv_q <= 1'b0;
      sck_q <= 1'b0;
    end else begin
      cnv_q <= convert_start;
      sck_q <= sck;
    end
  end

  // mode and busy choice as the converter should see them
  always_ff @(posedge CONV_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cs_q   <= 1'b0;
      busy_q <= 1'b0;
    end else if (convert_start && !cnv_q) begin
      cs_q   <= serial_in_select;
      busy_q <= !serial_in_select && sck;
    end else if (cs_q && CONVERTING && !(serial_in_select && convert_start)) begin
      busy_q <= 1'b1;
    end
  end

  // clock falls while the output is driven
  always_ff @(posedge CONV_CLK or negedge RST_N) begin
    if (!RST_N) falls_q <= 5'h0;
    else if (!serial_out_oe) falls_q <= 5'h0;
    else if (sck_q && !sck) falls_q <= falls_q + 5'h1;
  end

  low_power_a: assert property ($fell(CONVERTING) |-> ##[0:1] LOW_POWER)
    else $error("low power not entered after conversion");
  start_converts_a: assert property ($rose(convert_start) |-> ##[1:5] CONVERTING)
    else $error("start rise did not begin conversion");
  // bench runs the converter with 20 link cycles
  conv_length_a: assert property ($rose(CONVERTING) |-> CONVERTING[*8] ##1 CONVERTING[*8]
    ##[1:6] !CONVERTING)
    else $error("conversion length wrong");
  cs_float_a: assert property ($rose(convert_start) && serial_in_select
    |-> ##[1:5] !serial_out_oe)
    else $error("output not released on chip-select start");
  chain_start_bit_a: assert property (!cs_q && busy_q && $fell(CONVERTING)
    |-> ##[0:3] serial_out && serial_out_oe)
    else $error("chain start bit missing");
  chain_msb_a: assert property (!cs_q && !busy_q && $fell(CONVERTING)
    |-> ##[0:3] serial_out_oe && serial_out == SAMPLE[15])
    else $error("chain stage msb missing");
  busy_drive_a: assert property (cs_q && busy_q && $fell(CONVERTING)
    |-> ##[0:3] serial_out_oe)
    else $error("busy drive-on missing");
  late_msb_a: assert property (cs_q && !busy_q && !CONVERTING
    && $rose(!(serial_in_select && convert_start))
    |-> ##[1:5] serial_out_oe && serial_out == SAMPLE[15])
    else $error("msb not driven on late select");
  release_count_a: assert property (cs_q && $fell(sck) && falls_q == (busy_q ? 5'h10 : 5'h0f)
    |-> ##[1:6] !serial_out_oe)
    else $error("output not released after last fall");

  cover property (cs_q && busy_q && $fell(CONVERTING));
  cover property (cs_q && !busy_q && $rose(serial_out_oe));
  cover property (!cs_q && busy_q && $fell(CONVERTING));
  cover property (!cs_q && !busy_q && $fell(CONVERTING));
endmodule : asr_link_props

// ### verification/testbench.sv
// self-checking bench: host end and converter end joined by the link
`timescale 1ns/10ps
module testbench
  import asr_pkg::*;
;
  logic        mclk, conv_clk, rst_n, start, busy_en, done, low_power, converting;
  asr_mode_e   mode;
  logic [15:0] data, sample;
  logic        sdi_at_start, sck_at_start;
  int          fail_count, checks, falls, cycles;

  asr_if asr_if_i ();
  asr_host #(.BITS(16), .STAGES(1)) asr_host_i (.link(asr_if_i.host), .MCLK(mclk),
    .RST_N(rst_n), .START(start), .MODE(mode), .BUSY_EN(busy_en), .DONE(done), .DATA(data));
  asr_device #(.CONV_CYCLES(20), .BITS(16)) asr_device_i (.link(asr_if_i.device),
    .CONV_CLK(conv_clk), .RST_N(rst_n), .SAMPLE(sample), .LOW_POWER(low_power),
    .CONVERTING(converting));
  asr_link_props asr_link_props_i (.CONV_CLK(conv_clk), .RST_N(rst_n),
    .convert_start(asr_if_i.convert_start), .sck(asr_if_i.sck),
    .serial_in_select(asr_if_i.serial_in_select), .serial_out(asr_if_i.serial_out),
    .serial_out_oe(asr_if_i.serial_out_oe), .CONVERTING(converting),
    .LOW_POWER(low_power), .SAMPLE(sample));

  always #25 mclk = ~mclk;
  always #3 conv_clk = ~conv_clk;

  // wire levels at each sampling edge and clock falls per transfer
  always @(posedge asr_if_i.convert_start) begin
    sdi_at_start = asr_if_i.serial_in_select;
    sck_at_start = asr_if_i.sck;
  end
  // the chain busy-select level drops during conversion: not a read clock
  always @(negedge asr_if_i.sck) if (!converting) falls++;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      $display("[FAIL] run time limit reached");
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one whole transaction: start, wait for completion, compare
  task automatic run(input asr_mode_e m, input logic b, input logic [15:0] v);
    int n;
    n = 0;
    @(posedge mclk);
    mode    <= m;
    busy_en <= b;
    sample  <= v;
    start   <= 1'b1;
    falls = 0;
    @(posedge mclk);
    start <= 1'b0;
    while (done !== 1'b1 && n < 2000) begin
      @(negedge mclk);
      n++;
    end
    check("done seen", {15'h0, n < 2000}, 16'h0001);
    check("result", data, v);
    check("select at start", {15'h0, sdi_at_start}, {15'h0, m != ASR_MODE_CHAIN});
    check("sck at start", {15'h0, sck_at_start}, {15'h0, m == ASR_MODE_CHAIN && b});
    check("sck falls", 16'(falls), 16'(16 + b));
    check("low power", {15'h0, low_power}, 16'h0001);
    if (m != ASR_MODE_CHAIN)
      check("output released", {15'h0, asr_if_i.serial_out_oe}, 16'h0000);
    $display("test done: mode %s busy %0b", m.name(), b);
  endtask : run

  initial begin
    mclk = 0;
    conv_clk = 0;
    rst_n = 0;
    start = 0;
    mode = ASR_MODE_CS4;
    busy_en = 0;
    sample = 16'h0000;
    fail_count = 0;
    checks = 0;
    falls = 0;
    cycles = 0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    run(ASR_MODE_CS4, 1'b0, 16'h8001);
    run(ASR_MODE_CS4, 1'b1, 16'h7ffe);
    run(ASR_MODE_CS3, 1'b0, 16'hffff);
    run(ASR_MODE_CS3, 1'b1, 16'h0000);
    run(ASR_MODE_CHAIN, 1'b0, 16'ha5c3);
    run(ASR_MODE_CHAIN, 1'b1, 16'h5a3c);
    run(ASR_MODE_CS4, 1'b0, 16'h0001);
    // second reset between transactions, then traffic again
    rst_n <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    run(ASR_MODE_CHAIN, 1'b1, 16'hc001);
    tally_and_finish();
  end
endmodule : testbench
